// file: logic/gpt_pkg.sv
// Purpose: shared constants for the gated pulse totalizer and digital ports
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
package gpt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 26;
  localparam int PORT_W = 8;
  localparam int DIO_W  = 2 * PORT_W;
  localparam int IRQ_W  = 4;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_COUNT    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DIN      = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DOUT0    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_DOUT1    = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DOUT16   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_PAT0     = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_PAT1     = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_SCAN     = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_SNAPCNT  = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_SNAPDIN  = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_IRQSTAT  = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_IRQMASK  = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_CLEAR    = 8'h34;

  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int CTRL_EDGE_BIT = 0;
  localparam int CTRL_OE0_BIT  = 1;
  localparam int CTRL_OE1_BIT  = 2;
  localparam int PAT_VAL_LSB   = 0;
  localparam int PAT_CARE_LSB  = 8;
  localparam int PAT_MODE_BIT  = 16;
  localparam int PAT_W         = 17;
  localparam int CMD_BIT       = 0;
  localparam int IRQ_ALM0      = 0;
  localparam int IRQ_ALM1      = 1;
  localparam int IRQ_WRAP      = 2;
  localparam int IRQ_SCAN      = 3;

  // ----------------------------------------
  // values
  // ----------------------------------------
  localparam logic [CNT_W-1:0]  CNT_MAX    = 26'h3FFFFFF;
  localparam logic [CNT_W-1:0]  CNT_ONE    = 26'h0000001;
  localparam logic [PORT_W-1:0] DOUT_RST   = 8'hFF;
  localparam logic [PAT_W-1:0]  PAT_RST    = 17'h00000;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h00000000;

  typedef enum logic {EDGE_RISE, EDGE_FALL} edge_t;

endpackage

// file: logic/bit_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to clk
// Notes:   first stage is read only by the second
module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule

// file: logic/port_alarm.sv
// Purpose: pattern-match and pattern-change watcher for one 8-bit port
// Assumes: din already synchronised
// Notes:   runs always, independent of any scan
module port_alarm
  import gpt_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [gpt_pkg::PORT_W-1:0] din,
  input  wire logic [gpt_pkg::PAT_W-1:0]  cfg,
  output logic                       alarm
);

  typedef struct packed {
    logic [PORT_W-1:0] prev;
    logic              primed;
    logic              inMatch;
    logic              alarm;
  } alarm_t;

  alarm_t st_r;
  alarm_t st_nxt;

  logic [PORT_W-1:0] care;
  logic [PORT_W-1:0] want;

  assign care = cfg[PAT_CARE_LSB +: PORT_W];
  assign want = cfg[PAT_VAL_LSB +: PORT_W];

  always_comb begin
    st_nxt         = st_r;
    st_nxt.prev    = din;
    st_nxt.primed  = 1'b1;
    st_nxt.inMatch = ((din ^ want) & care) == '0;
    // match fires on entry only; change needs a prior sample
    if (cfg[PAT_MODE_BIT]) begin
      st_nxt.alarm = st_r.primed && (((din ^ st_r.prev) & care) != '0);
    end else begin
      // primed keeps the first sample after reset from looking like an entry
      st_nxt.alarm = st_r.primed && st_nxt.inMatch && !st_r.inMatch;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign alarm = st_r.alarm;

endmodule

// file: logic/gated_pulse_totalizer_dio.sv
// Purpose: gated 26-bit pulse totalizer with two 8-bit digital ports, APB slave
// Assumes: pull-ups on gate-high and port pins, pull-down on gate-low, are modelled on the wire
// Notes:   one APB wait state; outputs registered
module gated_pulse_totalizer_dio
  import gpt_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [gpt_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [gpt_pkg::DATA_W-1:0]   pwdata,
  output logic      [gpt_pkg::DATA_W-1:0]   prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         pulseIn,
  input  wire logic                         gateHigh,
  input  wire logic                         gateLow_n,
  input  wire logic [gpt_pkg::DIO_W-1:0]    dioIn,
  output logic      [gpt_pkg::DIO_W-1:0]    dioOut,
  output logic      [gpt_pkg::DIO_W-1:0]    dioOe,
  output logic                              irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    edge_t             edgeSel;
    logic [1:0]        portOe;
    logic [DIO_W-1:0]  dout;
    logic [PAT_W-1:0]  pat0;
    logic [PAT_W-1:0]  pat1;
    logic [CNT_W-1:0]  count;
    logic              pulsePrev;
    logic [CNT_W-1:0]  snapCount;
    logic [DIO_W-1:0]  snapDin;
    logic [IRQ_W-1:0]  stat;
    logic [IRQ_W-1:0]  mask;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
  } top_t;

  top_t st_r;
  top_t st_nxt;

  logic              pulseS;
  logic              gateHighS;
  logic              gateLowS_n;
  logic [DIO_W-1:0]  dinS;
  logic              alarm0;
  logic              alarm1;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  bit_sync #(.W(3)) ctlSync (
    .clk (clk),
    .rst (rst),
    .d   ({pulseIn, gateHigh, gateLow_n}),
    .q   ({pulseS, gateHighS, gateLowS_n})
  );

  // pull-ups on the pins make open bits read as 1
  bit_sync #(.W(DIO_W)) dinSync (
    .clk (clk),
    .rst (rst),
    .d   (dioIn),
    .q   (dinS)
  );

  // ----------------------------------------
  // pattern alarms
  // ----------------------------------------
  // watchers run free of the scan command
  port_alarm alarmLo (
    .clk   (clk),
    .rst   (rst),
    .din   (dinS[PORT_W-1:0]),
    .cfg   (st_r.pat0),
    .alarm (alarm0)
  );

  port_alarm alarmHi (
    .clk   (clk),
    .rst   (rst),
    .din   (dinS[DIO_W-1:PORT_W]),
    .cfg   (st_r.pat1),
    .alarm (alarm1)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    unique case (a)
      OFF_CTRL, OFF_COUNT, OFF_DIN, OFF_DOUT0, OFF_DOUT1, OFF_DOUT16,
      OFF_PAT0, OFF_PAT1, OFF_SCAN, OFF_SNAPCNT, OFF_SNAPDIN,
      OFF_IRQSTAT, OFF_IRQMASK, OFF_CLEAR: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] zext(input logic [DATA_W-1:0] v);
    zext = v;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic              pulseEdge;
  logic              gatesOpen;
  logic              countHit;
  logic              doWrite;
  logic              doScan;
  logic              doClear;
  logic [IRQ_W-1:0]  events;
  logic [IRQ_W-1:0]  w1c;
  logic [DATA_W-1:0] rdata;

  always_comb begin
    st_nxt    = st_r;
    events    = '0;
    w1c       = '0;
    rdata     = DATA_ZERO;
    doWrite   = st_r.pready && psel && penable && pwrite && !st_r.pslverr;
    doScan    = doWrite && (paddr == OFF_SCAN) && pwdata[CMD_BIT];
    doClear   = doWrite && (paddr == OFF_CLEAR) && pwdata[CMD_BIT];

    // edge detection on synchronised pulse
    st_nxt.pulsePrev = pulseS;
    if (st_r.edgeSel == EDGE_FALL) begin
      pulseEdge = st_r.pulsePrev && !pulseS;
    end else begin
      pulseEdge = !st_r.pulsePrev && pulseS;
    end
    // open gate pins float enabled, so no gate means always counting
    gatesOpen = gateHighS && !gateLowS_n;
    countHit  = pulseEdge && gatesOpen;

    // clear wins over a coincident pulse
    if (doClear) begin
      st_nxt.count = '0;
    end else if (countHit) begin
      st_nxt.count = st_r.count + CNT_ONE;
      if (st_r.count == CNT_MAX) begin
        events[IRQ_WRAP] = 1'b1;
      end
    end

    // scan step captures count and ports together
    if (doScan) begin
      st_nxt.snapCount = st_r.count;
      st_nxt.snapDin   = dinS;
      events[IRQ_SCAN] = 1'b1;
    end

    events[IRQ_ALM0] = alarm0;
    events[IRQ_ALM1] = alarm1;

    // read mux
    unique case (paddr)
      OFF_CTRL:    rdata = zext({29'h0, st_r.portOe, st_r.edgeSel});
      OFF_COUNT:   rdata = zext({6'h0, st_r.count});
      OFF_DIN:     rdata = zext({16'h0, dinS});
      OFF_DOUT0:   rdata = zext({24'h0, st_r.dout[PORT_W-1:0]});
      OFF_DOUT1:   rdata = zext({24'h0, st_r.dout[DIO_W-1:PORT_W]});
      OFF_DOUT16:  rdata = zext({16'h0, st_r.dout});
      OFF_PAT0:    rdata = zext({15'h0, st_r.pat0});
      OFF_PAT1:    rdata = zext({15'h0, st_r.pat1});
      OFF_SNAPCNT: rdata = zext({6'h0, st_r.snapCount});
      OFF_SNAPDIN: rdata = zext({16'h0, st_r.snapDin});
      OFF_IRQSTAT: rdata = zext({28'h0, st_r.stat});
      OFF_IRQMASK: rdata = zext({28'h0, st_r.mask});
      default:     rdata = DATA_ZERO;
    endcase

    // apb: answer one cycle into the access phase
    if (st_r.pready) begin
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata  = DATA_ZERO;
    end else if (psel && penable) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = !isMapped(paddr);
      st_nxt.prdata  = pwrite ? DATA_ZERO : rdata;
    end

    // writes land at the edge where pready is sampled
    if (doWrite) begin
      unique case (paddr)
        OFF_CTRL: begin
          st_nxt.edgeSel = edge_t'(pwdata[CTRL_EDGE_BIT]);
          st_nxt.portOe  = {pwdata[CTRL_OE1_BIT], pwdata[CTRL_OE0_BIT]};
        end
        OFF_DOUT0:   st_nxt.dout[PORT_W-1:0]     = pwdata[PORT_W-1:0];
        OFF_DOUT1:   st_nxt.dout[DIO_W-1:PORT_W] = pwdata[PORT_W-1:0];
        OFF_DOUT16:  st_nxt.dout                 = pwdata[DIO_W-1:0];
        OFF_PAT0:    st_nxt.pat0                 = pwdata[PAT_W-1:0];
        OFF_PAT1:    st_nxt.pat1                 = pwdata[PAT_W-1:0];
        OFF_IRQSTAT: w1c                         = pwdata[IRQ_W-1:0];
        OFF_IRQMASK: st_nxt.mask                 = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // a new event beats a simultaneous clear
    st_nxt.stat = (st_r.stat & ~w1c) | events;
    st_nxt.irq  = |(st_nxt.stat & st_nxt.mask);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r           <= '0;
      st_r.dout      <= {DOUT_RST, DOUT_RST};
      st_r.pat0      <= PAT_RST;
      st_r.pat1      <= PAT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // a port drives only once enabled, so input use is the reset state
  assign dioOut  = st_r.dout;
  assign dioOe   = {{PORT_W{st_r.portOe[1]}}, {PORT_W{st_r.portOe[0]}}};
  assign prdata  = st_r.prdata;
  assign pready  = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign irq     = st_r.irq;

endmodule

// file: tb/gpt_props.sv
// Purpose: port checks for the totalizer block
// Assumes: one clock, synchronous reset
// Notes:   bound to the top module
module gpt_props
  import gpt_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] dioOut,
  input wire logic [15:0] dioOe,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  wire wrDone = acc && pready && pwrite;
  // ----
  // bus
  // ----
  a_ready_wait: assert property (acc && !pready |=> pready)
    else $error("no answer one cycle after access");
  a_ready_late: assert property ($rose(acc) |-> !pready)
    else $error("answer came without wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_map: assert property (pready |-> pslverr == (paddr > OFF_CLEAR))
    else $error("error flag does not match address");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_count_width: assert property (pready && !pwrite && paddr == OFF_COUNT |-> prdata[31:26] == 6'h0)
    else $error("count wider than 26 bits");
  // ----
  // ports
  // ----
  a_dout_word: assert property (wrDone && paddr == OFF_DOUT16 |=> dioOut == $past(pwdata[15:0]))
    else $error("word write not on pins");
  a_dout_byte: assert property (wrDone && paddr == OFF_DOUT0 |=> dioOut[7:0] == $past(pwdata[7:0])
    && $stable(dioOut[15:8]))
    else $error("byte write wrong on pins");
  a_dout_hold: assert property (!$stable(dioOut) |-> $past(wrDone) || $past(rst))
    else $error("pins moved without a write");
  a_oe_bytes: assert property (dioOe[7:0] inside {8'h00, 8'hFF} && dioOe[15:8] inside {8'h00, 8'hFF})
    else $error("drive enable split inside a port");
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_word: cover property (wrDone && paddr == OFF_DOUT16);
endmodule

bind gated_pulse_totalizer_dio gpt_props u_gpt_props (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .dioOut(dioOut), .dioOe(dioOe), .irq(irq)
);

// file: tb/pin_model.sv
// Purpose: pins and contacts outside the block
// Assumes: pull-ups on gate-high and ports, pull-down on gate-low
// Notes:   a driven port bit wins over its contact
module pin_model (
  input  wire logic        pulseSrc,
  input  wire logic        hiCon,
  input  wire logic        hiVal,
  input  wire logic        loCon,
  input  wire logic        loVal,
  input  wire logic [15:0] closed,
  input  wire logic [15:0] dioOut,
  input  wire logic [15:0] dioOe,
  output logic             pulseIn,
  output logic             gateHigh,
  output logic             gateLow_n,
  output logic [15:0]      dioIn,
  output logic             swPos
);
  timeunit 1ns;
  timeprecision 100ps;
  assign pulseIn   = pulseSrc;
  assign gateHigh  = hiCon ? hiVal : 1'b1;
  assign gateLow_n = loCon ? loVal : 1'b0;
  // open contact floats high, closed one grounds it
  assign dioIn = (dioOe & dioOut) | (~dioOe & ~closed);
  // switch flips only while its bit is driven low
  assign swPos = dioOe[0] & ~dioOut[0];
endmodule

// file: tb/gated_pulse_totalizer_dio_tb.sv
// Purpose: self-checking bench for the totalizer block
// Assumes: 200 MHz clock, apb master below
// Notes:   wrap at full count is too long to reach here
module gated_pulse_totalizer_dio_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import gpt_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, er;
  logic        pulseSrc, hiCon, hiVal, loCon, loVal, pulseIn, gateHigh, gateLow_n, swPos;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] closed, dioIn, dioOut, dioOe;
  int          err_count = 0, n_checks = 0, cycles = 0;

  gated_pulse_totalizer_dio u_gated_pulse_totalizer_dio (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulseIn(pulseIn), .gateHigh(gateHigh),
    .gateLow_n(gateLow_n), .dioIn(dioIn), .dioOut(dioOut), .dioOe(dioOe), .irq(irq));
  pin_model u_pin_model (.pulseSrc(pulseSrc), .hiCon(hiCon), .hiVal(hiVal), .loCon(loCon),
    .loVal(loVal), .closed(closed), .dioOut(dioOut), .dioOe(dioOe), .pulseIn(pulseIn),
    .gateHigh(gateHigh), .gateLow_n(gateLow_n), .dioIn(dioIn), .swPos(swPos));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----
  // helpers
  // ----
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // idle edge at the end keeps psel from two writes in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      pulseSrc <= 1'b1; cyc(4); pulseSrc <= 1'b0; cyc(4);
    end
  endtask
  task automatic lvl(input logic v, input logic [31:0] exp);
    pulseSrc <= v; cyc(6); rdc(OFF_COUNT, exp);
  endtask
  task automatic gp(input logic hc, hv, lc, lv, input logic [31:0] exp);
    hiCon <= hc; hiVal <= hv; loCon <= lc; loVal <= lv;
    cyc(4); pulse(1); rdc(OFF_COUNT, exp);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    rdc(OFF_CTRL, 32'h0);
    rdc(OFF_COUNT, 32'h0);
    rdc(OFF_DIN, 32'h0000FFFF);
    rdc(8'h3C, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk({dioOe, dioOut}, 32'h0000FFFF);
    $display("test reset done");
  endtask
  task automatic t_edges;
    pulse(3); rdc(OFF_COUNT, 32'h3);
    lvl(1'b1, 32'h4);
    lvl(1'b0, 32'h4);
    wr(OFF_CTRL, 32'h1);
    lvl(1'b1, 32'h4);
    lvl(1'b0, 32'h5);
    wr(OFF_CTRL, 32'h0);
    $display("test edges done");
  endtask
  task automatic t_gates;
    gp(1'b1, 1'b0, 1'b0, 1'b0, 32'h5);
    gp(1'b1, 1'b1, 1'b1, 1'b1, 32'h5);
    gp(1'b1, 1'b0, 1'b1, 1'b1, 32'h5);
    gp(1'b1, 1'b1, 1'b1, 1'b0, 32'h6);
    hiCon <= 1'b0; loCon <= 1'b0;
    $display("test gates done");
  endtask
  task automatic t_alarm;
    wr(OFF_PAT0, 32'h0000FF0F); wr(OFF_IRQMASK, 32'h1);
    chk({31'h0, irq}, 32'h0);
    closed <= 16'h00F0; cyc(8);
    chk({31'h0, irq}, 32'h1);
    rdc(OFF_IRQSTAT, 32'h1);
    rdc(OFF_DIN, 32'h0000FF0F);
    wr(OFF_IRQSTAT, 32'h1); cyc(1);
    chk({31'h0, irq}, 32'h0);
    rdc(OFF_IRQSTAT, 32'h0);
    wr(OFF_PAT1, 32'h00010100); closed <= 16'h01F0; cyc(8);
    chk({31'h0, irq}, 32'h0);
    rdc(OFF_IRQSTAT, 32'h2);
    wr(OFF_IRQSTAT, 32'h2);
    $display("test alarm done");
  endtask
  task automatic t_scan;
    wr(OFF_IRQMASK, 32'h8); wr(OFF_SCAN, 32'h1); cyc(1);
    chk({31'h0, irq}, 32'h1);
    rdc(OFF_SNAPCNT, 32'h6);
    rdc(OFF_SNAPDIN, 32'h0000FE0F);
    wr(OFF_IRQSTAT, 32'h8);
    rdc(OFF_COUNT, 32'h6);
    wr(OFF_CLEAR, 32'h1);
    rdc(OFF_COUNT, 32'h0);
    $display("test scan done");
  endtask
  task automatic t_out;
    closed <= 16'h0000; wr(OFF_CTRL, 32'h6); wr(OFF_DOUT16, 32'h0000A55A);
    chk({dioOe, dioOut}, 32'hFFFFA55A);
    rdc(OFF_DIN, 32'h0000A55A);
    chk({31'h0, swPos}, 32'h1);
    wr(OFF_DOUT0, 32'h0000003C);
    chk({16'h0, dioOut}, 32'h0000A53C);
    wr(OFF_CTRL, 32'h4); wr(OFF_DOUT1, 32'h00000012);
    chk({dioOe, dioOut}, 32'hFF00123C);
    $display("test out done");
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_of_test;
    end
  end
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    pulseSrc = 1'b0; hiCon = 1'b0; hiVal = 1'b0; loCon = 1'b0; loVal = 1'b0; closed = 16'h0;
    cyc(16);
    rst <= 1'b0;
    cyc(1);
    t_reset; t_edges; t_gates; t_alarm; t_scan; t_out;
    end_of_test;
  end
endmodule
